// ===== tpx_pkg.sv
// Purpose: shared constants and types for the timer/port transfer executor
// Assumes: 32-bit Avalon-MM slave, byte addresses, one word per register
// Notes: register A/B/Y are the nibble working registers of the core
package tpx_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [5:0] ADR_REG_A = 6'h00; // working register A
  localparam logic [5:0] ADR_REG_B = 6'h04; // working register B
  localparam logic [5:0] ADR_REG_Y = 6'h08; // working register Y
  localparam logic [5:0] ADR_CMD = 6'h0C; // write: execute op, read: last op
  localparam logic [5:0] ADR_IRQCTL = 6'h10; // irq_control_reg_one
  localparam logic [5:0] ADR_T1 = 6'h14; // timer 1 count, read only
  localparam logic [5:0] ADR_T1RLD = 6'h18; // timer1_reload_reg
  localparam logic [5:0] ADR_T2 = 6'h1C; // timer 2 count, read only
  localparam logic [5:0] ADR_T2RLO = 6'h20; // timer2_reload_low_reg, read only
  localparam logic [5:0] ADR_T2RHI = 6'h24; // timer2_reload_high_reg, read only
  localparam logic [5:0] ADR_STAT = 6'h28; // flags and skip result
  localparam logic [5:0] ADR_TCTL = 6'h2C; // timer run bits
  localparam logic [5:0] ADR_PORTS = 6'h30; // output latches, read only
  localparam logic [5:0] ADR_DRV = 6'h34; // drive ctrl 0..3, read only
  localparam logic [5:0] ADR_WAKE = 6'h38; // keyon_wake_ctrl_0, read only

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int T1_IRQ_EN_BIT = 2; // timer1_irq_enable_bit in irq ctl
  localparam int T2_IRQ_EN_BIT = 3; // timer2_irq_enable_bit in irq ctl
  localparam int STAT_T1F_BIT = 0; // timer1_request_flag
  localparam int STAT_T2F_BIT = 1; // timer2_request_flag
  localparam int STAT_SKIP_BIT = 2; // last op asked for a skip
  localparam int TCTL_T1RUN_BIT = 0; // timer 1 counts
  localparam int TCTL_T2RUN_BIT = 1; // timer 2 counts
  localparam int D_BITS = 4; // valid D-port indices 0..3

  // ----------------------------------------------------------------
  // reset values and timing
  // ----------------------------------------------------------------
  localparam logic [3:0] NIB_RST = 4'h0; // nibble registers
  localparam logic [7:0] BYTE_RST = 8'h00; // timers and reloads
  localparam logic [3:0] D_RST = 4'hF; // D port idles high
  localparam int CLK_HZ = 50000000; // core clock rate
  localparam int TICK_NS = 1000; // timer tick period in ns
  localparam int TICK_CYC = TICK_NS / (1000000000 / CLK_HZ); // 50 cycles
  localparam logic [5:0] TICK_LAST = 6'(TICK_CYC - 1); // divider wrap

  // ----------------------------------------------------------------
  // operation codes written to the command register
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    OP_NOP = 5'h00,
    OP_RD_T2 = 5'h01,
    OP_LD_T2 = 5'h02,
    OP_LD_T2H = 5'h03,
    OP_RLD_T1 = 5'h04,
    OP_RLD_T2 = 5'h05,
    OP_SKIP_T1 = 5'h06,
    OP_SKIP_T2 = 5'h07,
    OP_RD_P0 = 5'h08,
    OP_WR_P0 = 5'h09,
    OP_RD_P1 = 5'h0A,
    OP_WR_P1 = 5'h0B,
    OP_RD_P2 = 5'h0C,
    OP_WR_P2 = 5'h0D,
    OP_SET_ALL_D = 5'h0E,
    OP_CLR_D = 5'h0F,
    OP_SET_D = 5'h10,
    OP_TEST_D = 5'h11,
    OP_WR_DRV0 = 5'h12,
    OP_WR_DRV1 = 5'h13,
    OP_WR_DRV2 = 5'h14,
    OP_WR_DRV3 = 5'h15,
    OP_WR_WAKE = 5'h16,
    OP_RD_WAKE = 5'h17
  } tpx_op_type;

  // output latches of the ports
  typedef struct packed {
    logic [3:0] p0;
    logic [3:0] p1;
    logic [1:0] p2;
    logic [3:0] d;
  } tpx_pout_type;

endpackage : tpx_pkg

// ===== tpx_exec.sv
// Purpose: executes timer and port transfer operations on command
// Assumes: software loads A, B, Y, then writes an op code to the command reg
// Notes: each op completes in the bus cycle that writes it
// Summary of operation
// (RULE1) read timer 2: high to B, low to A
// (RULE2) load B:A into timer 2 and low reload
// (RULE3) load B:A into high reload only
// (RULE4) reload timer 1 from its reload register
// (RULE5) reload timer 2 from low reload
// (RULE6) timer1 flag set: clear it and skip
// (RULE7) timer1 irq enabled: skip test is nop
// (RULE8) timer2 flag set: clear it and skip
// (RULE9) timer2 irq enabled: skip test is nop
// (RULE10) port zero inputs into A
// (RULE11) A onto port zero latches
// (RULE12) port one inputs into A
// (RULE13) A onto port one latches
// (RULE14) port two into A1:A0, A3 cleared
// (RULE15) A1:A0 onto port two latches
// (RULE16) clear D bit indexed by Y
// (RULE17) set D bit indexed by Y
// (RULE18) skip when indexed D bit is zero
// (RULE19) A into selected drive control register
// (RULE20) A into key-on wakeup control
// (RULE21) key-on wakeup control into A
// (RULE22) set every D output bit
// (RULE23) only Y values 0..3 select a D bit
`timescale 1ns/10ps

module tpx_exec
  import tpx_pkg::*;
(
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  input wire logic [5:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  input wire logic [3:0] AVS_BYTEENABLE_I,
  output logic [31:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  input wire logic [3:0] P0_I,
  input wire logic [3:0] P1_I,
  input wire logic [1:0] P2_I,
  output logic [3:0] P0_O,
  output logic [3:0] P1_O,
  output logic [1:0] P2_O,
  output logic [3:0] D_O,
  output logic [15:0] DRV_CTRL_O,
  output logic [3:0] WAKE_CTRL_O
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // one-hot mask of the D bit picked by Y; zero for out-of-range Y
  function automatic logic [3:0] d_mask(input logic [3:0] y);
    logic [3:0] m;
    m = 4'h0;
    if (y < 4'(D_BITS)) begin // RULE23
      m[y[1:0]] = 1'b1;
    end
    return m;
  endfunction : d_mask
  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic ack_reg; // second cycle of an access
  logic acc_wr; // write taken this edge
  logic [31:0] rdata_reg; // registered read data
  logic [3:0] a_reg; // working register A
  logic [3:0] b_reg; // working register B
  logic [3:0] y_reg; // working register Y
  tpx_op_type op; // op code from the bus
  tpx_op_type last_op_reg; // last executed op
  logic exec; // an op executes this edge
  logic [3:0] irqctl_reg; // irq_control_reg_one
  logic [1:0] tctl_reg; // timer run bits
  logic [7:0] t1_reg; // timer 1 count
  logic [7:0] t2_reg; // timer 2 count
  logic [7:0] t1rld_reg; // timer1_reload_reg
  logic [7:0] t2rlo_reg; // timer2_reload_low_reg
  logic [7:0] t2rhi_reg; // timer2_reload_high_reg
  logic t1f_reg; // timer1_request_flag
  logic t2f_reg; // timer2_request_flag
  logic skip_reg; // last op asked for a skip
  logic skip_next; // skip decision of this op
  logic t1f_clr; // skip op clears timer 1 flag
  logic t2f_clr; // skip op clears timer 2 flag
  logic [5:0] div_reg; // tick divider
  logic tick; // one-cycle timer enable
  logic t1_uf; // timer 1 underflow
  logic t2_uf; // timer 2 underflow
  tpx_pout_type pout_reg; // port output latches
  logic [15:0] drv_reg; // drive ctrl 3..0, a nibble each
  logic [3:0] wake_reg; // keyon_wake_ctrl_0
  logic [3:0] p0_s1_reg; // port zero sync stage 1
  logic [3:0] p0_s2_reg; // port zero sync stage 2
  logic [3:0] p1_s1_reg; // port one sync stage 1
  logic [3:0] p1_s2_reg; // port one sync stage 2
  logic [1:0] p2_s1_reg; // port two sync stage 1
  logic [1:0] p2_s2_reg; // port two sync stage 2

  // ----------------------------------------------------------------
  // avalon slave handshake
  // ----------------------------------------------------------------
  // every access takes two cycles: waitrequest drops in the second
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (AVS_READ_I | AVS_WRITE_I) & ~ack_reg;
    end
  end

  assign AVS_WAITREQUEST_O = (AVS_READ_I | AVS_WRITE_I) & ~ack_reg;
  assign acc_wr = AVS_WRITE_I & ack_reg & AVS_BYTEENABLE_I[0];
  assign op = tpx_op_type'(AVS_WRITEDATA_I[4:0]);
  assign exec = acc_wr & (AVS_ADDRESS_I == ADR_CMD);

  // read data is captured in the first cycle, shown in the second
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      rdata_reg <= 32'h0000_0000;
    end else if (AVS_READ_I & ~ack_reg) begin
      unique case (AVS_ADDRESS_I)
        ADR_REG_A: rdata_reg <= {28'h0, a_reg};
        ADR_REG_B: rdata_reg <= {28'h0, b_reg};
        ADR_REG_Y: rdata_reg <= {28'h0, y_reg};
        ADR_CMD: rdata_reg <= {27'h0, last_op_reg};
        ADR_IRQCTL: rdata_reg <= {28'h0, irqctl_reg};
        ADR_T1: rdata_reg <= {24'h0, t1_reg};
        ADR_T1RLD: rdata_reg <= {24'h0, t1rld_reg};
        ADR_T2: rdata_reg <= {24'h0, t2_reg};
        ADR_T2RLO: rdata_reg <= {24'h0, t2rlo_reg};
        ADR_T2RHI: rdata_reg <= {24'h0, t2rhi_reg};
        ADR_STAT: rdata_reg <= {29'h0, skip_reg, t2f_reg, t1f_reg};
        ADR_TCTL: rdata_reg <= {30'h0, tctl_reg};
        ADR_PORTS: rdata_reg <= {18'h0, pout_reg};
        ADR_DRV: rdata_reg <= {16'h0, drv_reg};
        ADR_WAKE: rdata_reg <= {28'h0, wake_reg};
        default: rdata_reg <= 32'h0000_0000; // unmapped reads zero
      endcase
    end
  end

  assign AVS_READDATA_O = rdata_reg;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // two flops on every port input before use
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      p0_s1_reg <= NIB_RST;
      p0_s2_reg <= NIB_RST;
      p1_s1_reg <= NIB_RST;
      p1_s2_reg <= NIB_RST;
      p2_s1_reg <= 2'h0;
      p2_s2_reg <= 2'h0;
    end else begin
      p0_s1_reg <= P0_I;
      p0_s2_reg <= p0_s1_reg;
      p1_s1_reg <= P1_I;
      p1_s2_reg <= p1_s1_reg;
      p2_s1_reg <= P2_I;
      p2_s2_reg <= p2_s1_reg;
    end
  end

  // ----------------------------------------------------------------
  // working registers
  // ----------------------------------------------------------------
  // A is loaded by the bus or by a transfer op
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      a_reg <= NIB_RST;
    end else if (acc_wr & (AVS_ADDRESS_I == ADR_REG_A)) begin
      a_reg <= AVS_WRITEDATA_I[3:0];
    end else if (exec) begin
      unique case (op)
        OP_RD_T2: a_reg <= t2_reg[3:0]; // RULE1
        OP_RD_P0: a_reg <= p0_s2_reg; // RULE10
        OP_RD_P1: a_reg <= p1_s2_reg; // RULE12
        OP_RD_P2: a_reg <= {2'b00, p2_s2_reg}; // RULE14
        OP_RD_WAKE: a_reg <= wake_reg; // RULE21
        default: a_reg <= a_reg; // other ops keep A
      endcase
    end
  end

  // B and Y are loaded by the bus; B also by a timer read
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      b_reg <= NIB_RST;
      y_reg <= NIB_RST;
    end else begin
      if (acc_wr & (AVS_ADDRESS_I == ADR_REG_B)) begin
        b_reg <= AVS_WRITEDATA_I[3:0];
      end else if (exec & (op == OP_RD_T2)) begin
        b_reg <= t2_reg[7:4]; // RULE1
      end
      if (acc_wr & (AVS_ADDRESS_I == ADR_REG_Y)) begin
        y_reg <= AVS_WRITEDATA_I[3:0];
      end
    end
  end

  // control registers written straight from the bus
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      irqctl_reg <= NIB_RST;
      tctl_reg <= 2'b00;
      t1rld_reg <= BYTE_RST;
    end else begin
      if (acc_wr & (AVS_ADDRESS_I == ADR_IRQCTL)) begin
        irqctl_reg <= AVS_WRITEDATA_I[3:0];
      end
      if (acc_wr & (AVS_ADDRESS_I == ADR_TCTL)) begin
        tctl_reg <= AVS_WRITEDATA_I[1:0];
      end
      if (acc_wr & (AVS_ADDRESS_I == ADR_T1RLD)) begin
        t1rld_reg <= AVS_WRITEDATA_I[7:0];
      end
    end
  end

  // last executed op, for software to read back
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      last_op_reg <= OP_NOP;
    end else if (exec) begin
      last_op_reg <= op;
    end
  end

  // ----------------------------------------------------------------
  // timers
  // ----------------------------------------------------------------
  // divider gives a one-cycle tick every microsecond
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      div_reg <= 6'h00;
    end else if (div_reg == TICK_LAST) begin
      div_reg <= 6'h00;
    end else begin
      div_reg <= div_reg + 6'h01;
    end
  end

  assign tick = (div_reg == TICK_LAST);
  assign t1_uf = tick & tctl_reg[TCTL_T1RUN_BIT] & (t1_reg == 8'h00);
  assign t2_uf = tick & tctl_reg[TCTL_T2RUN_BIT] & (t2_reg == 8'h00);

  // timer 1 counts down, reloads on underflow or on command
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      t1_reg <= BYTE_RST;
    end else if (exec & (op == OP_RLD_T1)) begin
      t1_reg <= t1rld_reg; // RULE4
    end else if (t1_uf) begin
      t1_reg <= t1rld_reg;
    end else if (tick & tctl_reg[TCTL_T1RUN_BIT]) begin
      t1_reg <= t1_reg - 8'h01;
    end
  end

  // timer 2 counts down; commands override the count
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      t2_reg <= BYTE_RST;
    end else if (exec & (op == OP_LD_T2)) begin
      t2_reg <= {b_reg, a_reg}; // RULE2
    end else if (exec & (op == OP_RLD_T2)) begin
      t2_reg <= t2rlo_reg; // RULE5
    end else if (t2_uf) begin
      t2_reg <= t2rlo_reg;
    end else if (tick & tctl_reg[TCTL_T2RUN_BIT]) begin
      t2_reg <= t2_reg - 8'h01;
    end
  end

  // timer 2 reload registers, loaded only by ops
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      t2rlo_reg <= BYTE_RST;
      t2rhi_reg <= BYTE_RST;
    end else if (exec) begin
      if (op == OP_LD_T2) begin
        t2rlo_reg <= {b_reg, a_reg}; // RULE2
      end
      if (op == OP_LD_T2H) begin
        t2rhi_reg <= {b_reg, a_reg}; // RULE3
      end
    end
  end

  // ----------------------------------------------------------------
  // skip decisions and request flags
  // ----------------------------------------------------------------
  // skip tests are nops while the matching irq enable is set
  always_comb begin
    skip_next = 1'b0;
    t1f_clr = 1'b0;
    t2f_clr = 1'b0;
    unique case (op)
      OP_SKIP_T1: begin
        if (!irqctl_reg[T1_IRQ_EN_BIT] && t1f_reg) begin // RULE7
          skip_next = 1'b1; // RULE6
          t1f_clr = 1'b1;
        end
      end
      OP_SKIP_T2: begin
        if (!irqctl_reg[T2_IRQ_EN_BIT] && t2f_reg) begin // RULE9
          skip_next = 1'b1; // RULE8
          t2f_clr = 1'b1;
        end
      end
      OP_TEST_D: skip_next = |(d_mask(y_reg) & ~pout_reg.d); // RULE18
      default: skip_next = 1'b0; // no skip for other ops
    endcase
  end

  // flags set on underflow; a set in the clear cycle wins
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      t1f_reg <= 1'b0;
      t2f_reg <= 1'b0;
    end else begin
      if (t1_uf) begin
        t1f_reg <= 1'b1;
      end else if (exec & t1f_clr) begin
        t1f_reg <= 1'b0; // RULE6
      end
      if (t2_uf) begin
        t2f_reg <= 1'b1;
      end else if (exec & t2f_clr) begin
        t2f_reg <= 1'b0; // RULE8
      end
    end
  end

  // skip result of the last op, read back in the status register
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      skip_reg <= 1'b0;
    end else if (exec) begin
      skip_reg <= skip_next;
    end
  end

  // ----------------------------------------------------------------
  // port output latches
  // ----------------------------------------------------------------
  // latches change only on their own ops
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      pout_reg <= '{p0: NIB_RST, p1: NIB_RST, p2: 2'b00, d: D_RST};
    end else if (exec) begin
      unique case (op)
        OP_WR_P0: pout_reg.p0 <= a_reg; // RULE11
        OP_WR_P1: pout_reg.p1 <= a_reg; // RULE13
        OP_WR_P2: pout_reg.p2 <= a_reg[1:0]; // RULE15
        OP_SET_ALL_D: pout_reg.d <= D_RST; // RULE22
        OP_CLR_D: pout_reg.d <= pout_reg.d & ~d_mask(y_reg); // RULE16
        OP_SET_D: pout_reg.d <= pout_reg.d | d_mask(y_reg); // RULE17
        default: pout_reg <= pout_reg; // other ops keep latches
      endcase
    end
  end

  assign P0_O = pout_reg.p0;
  assign P1_O = pout_reg.p1;
  assign P2_O = pout_reg.p2;
  assign D_O = pout_reg.d;

  // ----------------------------------------------------------------
  // drive and wakeup control
  // ----------------------------------------------------------------
  // drive ctrl n takes nibble n; wakeup ctrl takes A
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      drv_reg <= 16'h0000;
      wake_reg <= NIB_RST;
    end else if (exec) begin
      unique case (op)
        OP_WR_DRV0: drv_reg[3:0] <= a_reg; // RULE19
        OP_WR_DRV1: drv_reg[7:4] <= a_reg; // RULE19
        OP_WR_DRV2: drv_reg[11:8] <= a_reg; // RULE19
        OP_WR_DRV3: drv_reg[15:12] <= a_reg; // RULE19
        OP_WR_WAKE: wake_reg <= a_reg; // RULE20
        default: wake_reg <= wake_reg; // other ops keep them
      endcase
    end
  end

  assign DRV_CTRL_O = drv_reg;
  assign WAKE_CTRL_O = wake_reg;
endmodule : tpx_exec

// ===== tpx_exec_asserts.sv
// Purpose: concurrent checks on the executor's bus and its P0, P2, D, drive ctrl and wake ctrl outputs
// Assumes: sees only the ports of tpx_exec, one clock domain
// Notes: bound to every tpx_exec instance below the module
`timescale 1ns/10ps

module tpx_exec_asserts
  import tpx_pkg::*;
(
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  input wire logic [5:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  input wire logic [3:0] AVS_BYTEENABLE_I,
  input wire logic [31:0] AVS_READDATA_O,
  input wire logic AVS_WAITREQUEST_O,
  input wire logic [3:0] P0_O,
  input wire logic [1:0] P2_O,
  input wire logic [3:0] D_O,
  input wire logic [15:0] DRV_CTRL_O,
  input wire logic [3:0] WAKE_CTRL_O
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);
  logic req; // any bus request
  logic cmd_go; // command write accepted at this edge
  logic [4:0] code_w; // op code on the write data
  assign req = AVS_READ_I | AVS_WRITE_I;
  assign cmd_go = AVS_WRITE_I & !AVS_WAITREQUEST_O & (AVS_ADDRESS_I == ADR_CMD) & AVS_BYTEENABLE_I[0];
  assign code_w = AVS_WRITEDATA_I[4:0];
  // accepted command carrying one op code
  sequence cmd_sq(logic [4:0] code);
    cmd_go && (code_w == code);
  endsequence

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  wait_first_a: assert property (req && !$past(req) |-> AVS_WAITREQUEST_O)
    else $error("waitrequest low in first cycle of an access");
  one_wait_a: assert property (req && AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O)
    else $error("more than one wait state");
  unmapped_zero_a: assert property (AVS_READ_I && !AVS_WAITREQUEST_O && AVS_ADDRESS_I == 6'h3C
    |-> AVS_READDATA_O == 32'h0) else $error("unmapped read not zero");
  p0_hold_a: assert property (!(cmd_go && code_w == OP_WR_P0) |=> $stable(P0_O))
    else $error("port zero latch changed without its op");
  p2_hold_a: assert property (!(cmd_go && code_w == OP_WR_P2) |=> $stable(P2_O))
    else $error("port two latch changed without its op");
  d_hold_a: assert property (!(cmd_go && code_w inside {OP_SET_ALL_D, OP_CLR_D, OP_SET_D})
    |=> $stable(D_O)) else $error("D latch changed without a D op");
  d_clr_only_a: assert property (cmd_sq(OP_CLR_D) |=> (D_O & ~$past(D_O)) == 4'h0)
    else $error("clear op raised a D bit");
  d_set_only_a: assert property (cmd_sq(OP_SET_D) |=> (~D_O & $past(D_O)) == 4'h0)
    else $error("set op lowered a D bit");
  set_all_a: assert property (cmd_sq(OP_SET_ALL_D) |=> D_O == 4'hF)
    else $error("set all did not drive D high");
  drv_zero_only_a: assert property (cmd_sq(OP_WR_DRV0) |=> $stable(DRV_CTRL_O[15:4]))
    else $error("drive ctrl 0 write touched other nibbles");
  wake_hold_a: assert property (!(cmd_go && code_w == OP_WR_WAKE) |=> $stable(WAKE_CTRL_O))
    else $error("wake ctrl changed without its op");
endmodule : tpx_exec_asserts

bind tpx_exec tpx_exec_asserts u_chk (.CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I), .AVS_ADDRESS_I(AVS_ADDRESS_I),
  .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I), .AVS_WRITEDATA_I(AVS_WRITEDATA_I),
  .AVS_BYTEENABLE_I(AVS_BYTEENABLE_I), .AVS_READDATA_O(AVS_READDATA_O), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O),
  .P0_O(P0_O), .P2_O(P2_O), .D_O(D_O), .DRV_CTRL_O(DRV_CTRL_O), .WAKE_CTRL_O(WAKE_CTRL_O));

// ===== tpx_pins.sv
// Purpose: far side of the ports, drives pin levels into the block
// Assumes: levels change only just after a rising clock edge
// Notes: D and output latches are watched by the bench directly
`timescale 1ns/10ps

module tpx_pins
  import tpx_pkg::*;
(
  input wire logic clk_i,
  input wire tpx_pout_type lvl_i,
  output logic [3:0] p0_o,
  output logic [3:0] p1_o,
  output logic [1:0] p2_o
);
  // ----------------------------------------------------------------
  // pin drivers: levels land on the edge after the bench asks
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    p0_o <= lvl_i.p0; // port zero input levels
    p1_o <= lvl_i.p1; // port one input levels
    p2_o <= lvl_i.p2; // port two input levels
  end
endmodule : tpx_pins

// ===== tpx_exec_tb_top.sv
// Purpose: self-checking bench for the timer and port transfer executor
// Assumes: Avalon-MM master with one idle edge between accesses
// Notes: timers are run briefly by their run bits to raise flags
`timescale 1ns/10ps

module tpx_exec_tb_top
  import tpx_pkg::*;
;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic clk = 1'b0; // 50 MHz core clock
  logic rst = 1'b1; // synchronous reset
  logic [5:0] adr = 6'h00; // bus address
  logic rd = 1'b0; // read request
  logic wr = 1'b0; // write request
  logic [31:0] wdat = 32'h0; // write data
  logic [3:0] be = 4'hF; // byte enables
  logic [31:0] rdat; // read data
  logic wreq; // waitrequest
  logic [3:0] p0_in, p1_in, p0_out, p1_out, d_out, wake_out;
  logic [1:0] p2_in, p2_out;
  logic [15:0] drv_out;
  tpx_pout_type lvl = '0; // requested pin levels
  int num_errors = 0;
  int compares = 0;
  int cycles = 0;
  logic [31:0] r; // scratch read value

  initial begin
    forever #10 clk = ~clk;
  end

  tpx_exec DUT (.CLK_I(clk), .SYS_RST_I(rst), .AVS_ADDRESS_I(adr), .AVS_READ_I(rd), .AVS_WRITE_I(wr),
    .AVS_WRITEDATA_I(wdat), .AVS_BYTEENABLE_I(be), .AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(wreq),
    .P0_I(p0_in), .P1_I(p1_in), .P2_I(p2_in), .P0_O(p0_out), .P1_O(p1_out), .P2_O(p2_out),
    .D_O(d_out), .DRV_CTRL_O(drv_out), .WAKE_CTRL_O(wake_out));
  tpx_pins u_pins (.clk_i(clk), .lvl_i(lvl), .p0_o(p0_in), .p1_o(p1_in), .p2_o(p2_in));

  // ----------------------------------------------------------------
  // common tasks
  // ----------------------------------------------------------------
  task report_and_stop;
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop

  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      report_and_stop();
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // one access, held until waitrequest is sampled low
  task bus(input logic [5:0] a, input logic w, input logic [31:0] d, input logic [3:0] b);
    adr <= a;
    wdat <= d;
    be <= b;
    if (w) wr <= 1'b1;
    else rd <= 1'b1;
    do @(posedge clk); while (wreq !== 1'b0);
    r = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
  endtask : bus

  task wrr(input logic [5:0] a, input logic [31:0] d);
    bus(a, 1'b1, d, 4'hF);
  endtask : wrr

  task rdr(input logic [5:0] a);
    bus(a, 1'b0, 32'h0, 4'hF);
  endtask : rdr

  task op(input logic [4:0] c);
    wrr(ADR_CMD, {27'h0, c});
  endtask : op

  task run(input logic [31:0] bits, input int n);
    wrr(ADR_TCTL, bits);
    repeat (n) @(posedge clk);
    wrr(ADR_TCTL, 32'h0);
  endtask : run

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task t_timer;
    wrr(ADR_REG_B, 32'hA);
    wrr(ADR_REG_A, 32'h5);
    op(OP_LD_T2);
    rdr(ADR_T2); chk(r, 32'hA5);
    rdr(ADR_T2RLO); chk(r, 32'hA5);
    wrr(ADR_REG_B, 32'h3);
    wrr(ADR_REG_A, 32'hC);
    op(OP_LD_T2H);
    rdr(ADR_T2RHI); chk(r, 32'h3C);
    rdr(ADR_T2); chk(r, 32'hA5);
    op(OP_RD_T2);
    rdr(ADR_REG_B); chk(r, 32'hA);
    rdr(ADR_REG_A); chk(r, 32'h5);
    run(32'h2, 120);
    rdr(ADR_T2);
    chk(r, 32'hA2);
    op(OP_RLD_T2);
    rdr(ADR_T2); chk(r, 32'hA5);
    wrr(ADR_T1RLD, 32'h37);
    op(OP_RLD_T1);
    rdr(ADR_T1); chk(r, 32'h37);
    $display("test timer done");
  endtask : t_timer

  task t_skip;
    for (int i = 0; i < 2; i++) begin
      wrr(ADR_T1RLD, 32'h0);
      wrr(ADR_REG_A, 32'h0);
      wrr(ADR_REG_B, 32'h0);
      op(i == 0 ? OP_RLD_T1 : OP_LD_T2);
      run(32'h1 << i, 60);
      wrr(ADR_IRQCTL, 32'h4 << i);
      op(OP_SKIP_T1 + 5'(i));
      rdr(ADR_STAT); chk(r & 32'h4 | (r >> i) & 32'h1, 32'h1);
      wrr(ADR_IRQCTL, 32'h0);
      op(OP_SKIP_T1 + 5'(i));
      rdr(ADR_STAT); chk(r & 32'h4 | (r >> i) & 32'h1, 32'h4);
      op(OP_SKIP_T1 + 5'(i));
      rdr(ADR_STAT); chk(r & 32'h4 | (r >> i) & 32'h1, 32'h0);
    end
    $display("test skip done");
  endtask : t_skip

  task t_ports;
    lvl <= '{p0: 4'h9, p1: 4'h6, p2: 2'h3, d: 4'h0};
    repeat (4) @(posedge clk);
    op(OP_RD_P0);
    rdr(ADR_REG_A); chk(r, 32'h9);
    op(OP_RD_P1);
    rdr(ADR_REG_A); chk(r, 32'h6);
    wrr(ADR_REG_A, 32'hF);
    op(OP_RD_P2);
    rdr(ADR_REG_A); chk(r & 32'hB, 32'h3);
    wrr(ADR_REG_A, 32'hC);
    op(OP_WR_P0); chk(p0_out, 32'hC);
    wrr(ADR_REG_A, 32'h3);
    op(OP_WR_P1); chk(p1_out, 32'h3);
    wrr(ADR_REG_A, 32'hE);
    op(OP_WR_P2); chk(p2_out, 32'h2);
    $display("test ports done");
  endtask : t_ports

  // D op on bit y, then D latch and skip result
  task dop(input logic [4:0] c, input logic [3:0] y, input logic [3:0] d, input logic s);
    wrr(ADR_REG_Y, {28'h0, y});
    op(c);
    chk(d_out, d);
    rdr(ADR_STAT); chk(r[STAT_SKIP_BIT], s);
  endtask : dop

  task t_portd;
    dop(OP_CLR_D, 4'h2, 4'hB, 1'b0);
    dop(OP_TEST_D, 4'h2, 4'hB, 1'b1);
    dop(OP_TEST_D, 4'h0, 4'hB, 1'b0);
    dop(OP_CLR_D, 4'h5, 4'hB, 1'b0);
    dop(OP_TEST_D, 4'h6, 4'hB, 1'b0);
    dop(OP_SET_D, 4'h2, 4'hF, 1'b0);
    dop(OP_CLR_D, 4'h0, 4'hE, 1'b0);
    dop(OP_CLR_D, 4'h3, 4'h6, 1'b0);
    dop(OP_SET_ALL_D, 4'h1, 4'hF, 1'b0);
    $display("test port d done");
  endtask : t_portd

  task t_ctrl;
    logic [15:0] e;
    e = 16'h0;
    for (int n = 0; n < 4; n++) begin
      wrr(ADR_REG_A, 32'h9 + n);
      op(OP_WR_DRV0 + 5'(n));
      e[4*n +: 4] = 4'(9 + n);
      chk(drv_out, e);
    end
    wrr(ADR_REG_A, 32'h7);
    op(OP_WR_WAKE); chk(wake_out, 32'h7);
    wrr(ADR_REG_A, 32'h0);
    op(OP_RD_WAKE);
    rdr(ADR_REG_A); chk(r, 32'h7);
    rdr(6'h3C); chk(r, 32'h0);
    wrr(ADR_T1, 32'h55);
    rdr(ADR_T1); chk(r, 32'h0);
    bus(ADR_REG_A, 1'b1, 32'h1, 4'h0);
    rdr(ADR_REG_A); chk(r, 32'h7);
    $display("test ctrl done");
  endtask : t_ctrl

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk(d_out, 32'hF);
    t_timer();
    t_skip();
    t_ports();
    t_portd();
    t_ctrl();
    report_and_stop();
  end
endmodule : tpx_exec_tb_top
